// ==== rtl/sleep_and_autoreply_control.sv ====
/*
  Sleep-mode control and automatic-reply transmit logic of the bridge.
  Assumes a host serial front end that delivers framed bytes, a UART
  transmitter with a ready handshake and a receiver that flags preambles.
*/
// Function
// RULE1 - host writes the sleep request bit to enter sleep monitoring
// RULE2 - sleep entry refused during config verify, config load or safe monitoring
// RULE3 - sleep request bit clears itself whenever sleep is left
// RULE4 - commanded-mode alert packets stop once sleep is entered
// RULE5 - in sleep, alert packets only if enabled, at the scan interval
// RULE6 - sleep config holds a host-programmable balance-notify timeout
// RULE7 - balance timeout exits sleep, sets exit flag, raises alert output
// RULE8 - with auto reply set, each valid preamble resends the whole transmit buffer; preambles arriving while tx_busy is set are ignored
// RULE9 - host loads the reply with the load-queue write, up to buffer size
// RULE10 - auto reply inactive in safe monitoring or sleep
// RULE11 - command 20h writes alert enables; 88h enables rx error and overflow alerts
// RULE12 - command 66h with data 40h sets automatic reply enable
// RULE13 - load-queue write is C0h, length byte, then that many bytes
// RULE14 - command B0h transmits the load queue on the UART
// RULE15 - command 01h returns receive status, 11h when buffer empty
// RULE16 - chain error during safe monitoring sets opstate status bit 1
// RULE17 - transactions in sleep or safe monitoring rejected, SPI error flagged
// RULE18 - refused sleep request leaves bit clear and mode unchanged
module sleep_and_autoreply_control
  import sleep_autoreply_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // host byte port
  input  wire host_byte_t host_in,
  output logic [7:0]      host_reply_out,
  // device state
  input  wire logic       cfg_verify_busy_in,
  input  wire logic       cfg_load_busy_in,
  input  wire logic       safe_monitor_mode_in,
  input  wire logic       chain_error_in,
  input  wire logic       commanded_alert_packet_cfg_in,
  input  wire logic [7:0] alert_packet_interval_in,
  // uart side
  input  wire logic       preamble_in,
  input  wire logic [7:0] rx_status_in,
  input  wire logic       rx_error_in,
  input  wire logic       rx_overflow_in,
  input  wire logic       uart_ready_in,
  output uart_byte_t      uart_tx_out,
  output logic            rx_clear_out,
  // status
  output logic            sleep_active_out,
  output logic            alert_packet_out,
  output logic            alert_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  parse_state_t         state;
  logic [7:0]           cmd;
  logic [7:0]           alert_enable;
  logic [7:0]           tx_cfg;
  logic [7:0]           sleep_config_register;
  logic                 sleep_request_bit;
  logic                 sleep_exit_flag;
  logic                 safe_monitor_chain_error;
  logic                 spi_error;
  logic [7:0]           tx_buf [TX_BUF_DEPTH];
  logic [7:0]           tx_len;
  logic [7:0]           load_len;
  logic [TX_PTR_W-1:0]  wr_ptr;
  logic [TX_PTR_W-1:0]  rd_ptr;
  logic                 tx_busy;
  logic [31:0]          tick_cnt;
  logic [7:0]           bal_cnt;
  logic [7:0]           pkt_cnt;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic byte_in      = host_in.frame && host_in.valid;
  wire logic cmd_byte     = byte_in && (state == ST_CMD);
  wire logic data_byte    = byte_in && (state == ST_DATA);
  wire logic busy_mode    = sleep_request_bit || safe_monitor_mode_in;
  // only status reads and the sleep register get through while asleep
  wire logic cmd_allowed  = (host_in.data == CMD_WR_SLEEP) || (host_in.data == CMD_RD_GEN_STATUS)
                         || (host_in.data == CMD_RD_OPSTATE_ALERT) || (host_in.data == CMD_RD_OPSTATE_STATUS)
                         || (host_in.data == CMD_RD_RX_STATUS);
  wire logic cmd_reject   = cmd_byte && busy_mode && !cmd_allowed;
  wire logic cmd_ok       = cmd_byte && !cmd_reject;
  wire logic rd_gen       = cmd_ok && (host_in.data == CMD_RD_GEN_STATUS);
  wire logic rd_op_alert  = cmd_ok && (host_in.data == CMD_RD_OPSTATE_ALERT);
  wire logic rd_op_status = cmd_ok && (host_in.data == CMD_RD_OPSTATE_STATUS);
  wire logic sleep_wr     = data_byte && (cmd == CMD_WR_SLEEP);
  wire logic sleep_block  = cfg_verify_busy_in || cfg_load_busy_in || safe_monitor_mode_in;
  wire logic sleep_enter  = sleep_wr && host_in.data[SLEEP_REQ_BIT] && !sleep_block;
  wire logic tick         = (tick_cnt == 32'(TICK_CYC - 1));
  wire logic [7:0] bal_limit  = 8'(sleep_config_register[BAL_TIMEOUT_LSB +: BAL_TIMEOUT_W]);
  wire logic bal_expire   = sleep_request_bit && (bal_limit != 8'h00) && tick && (bal_cnt == bal_limit - 8'h01);
  wire logic sleep_leave  = sleep_request_bit && (bal_expire || safe_monitor_mode_in
                         || (sleep_wr && !host_in.data[SLEEP_REQ_BIT]));
  wire logic [7:0] scan_limit = 8'(sleep_config_register[SCAN_INTERVAL_LSB +: SCAN_INTERVAL_W]) + 8'h01;
  wire logic [7:0] pkt_limit  = sleep_request_bit ? scan_limit : alert_packet_interval_in + 8'h01;
  wire logic pkt_enable   = sleep_request_bit ? sleep_config_register[SLP_ALERT_EN_BIT]
                         : (commanded_alert_packet_cfg_in && !safe_monitor_mode_in);
  wire logic auto_fire    = tx_cfg[TX_AUTO_BIT] && preamble_in && !busy_mode;
  wire logic queue_fire   = cmd_ok && (host_in.data == CMD_TX_QUEUE);
  wire logic tx_start     = !tx_busy && (tx_len != 8'h00) && (auto_fire || queue_fire);
  wire logic tx_load      = tx_busy && (!uart_tx_out.valid || uart_ready_in);
  wire logic tx_last      = ({2'b00, rd_ptr} == tx_len - 8'h01);
  wire logic buf_wr       = byte_in && (state == ST_LOAD);
  wire logic load_last    = ({2'b00, wr_ptr} == load_len - 8'h01);
  wire logic [7:0] len_cap = (host_in.data > TX_BUF_MAX) ? TX_BUF_MAX : host_in.data;

  // ---------------------------------------------------------------
  // command parser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state <= ST_CMD;
      cmd   <= REG_RESET;
    end else if (!host_in.frame) begin
      state <= ST_CMD;
    end else if (host_in.valid) begin
      case (state)
        ST_CMD: begin
          cmd <= host_in.data;
          if (cmd_reject) begin
            state <= ST_SKIP; // RULE17
          end else begin
            case (host_in.data)
              CMD_WR_ALERT_EN, CMD_WR_TX_CFG, CMD_WR_SLEEP, CMD_WR_SLEEP_CFG: state <= ST_DATA;
              CMD_WR_LOAD_Q: state <= ST_LEN; // RULE13
              default: state <= ST_SKIP;
            endcase
          end
        end
        ST_DATA: state <= ST_SKIP;
        ST_LEN:  state <= (len_cap == 8'h00) ? ST_SKIP : ST_LOAD; // RULE13
        ST_LOAD: state <= load_last ? ST_SKIP : ST_LOAD; // RULE9
        default: state <= ST_SKIP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // host-written registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      alert_enable          <= REG_RESET;
      tx_cfg                <= REG_RESET;
      sleep_config_register <= REG_RESET;
    end else if (data_byte) begin
      if (cmd == CMD_WR_ALERT_EN)
        alert_enable <= host_in.data; // RULE11
      if (cmd == CMD_WR_TX_CFG)
        tx_cfg <= host_in.data; // RULE12
      if (cmd == CMD_WR_SLEEP_CFG)
        sleep_config_register <= host_in.data; // RULE6
    end
  end

  // ---------------------------------------------------------------
  // sleep mode
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sleep_request_bit <= 1'b0;
    end else if (sleep_leave) begin
      sleep_request_bit <= 1'b0; // RULE3
    end else if (sleep_enter) begin
      sleep_request_bit <= 1'b1; // RULE1 RULE2 RULE18
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tick_cnt <= 32'h0000_0000;
      bal_cnt  <= 8'h00;
      pkt_cnt  <= 8'h00;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (!sleep_request_bit || sleep_enter)
        bal_cnt <= 8'h00;
      else if (tick)
        bal_cnt <= bal_cnt + 8'h01; // RULE6
      // interval restarts at each mode change
      if (sleep_enter || sleep_leave || !pkt_enable)
        pkt_cnt <= 8'h00; // RULE4
      else if (tick)
        pkt_cnt <= (pkt_cnt == pkt_limit - 8'h01) ? 8'h00 : pkt_cnt + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // flags, set wins over clear-on-read
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sleep_exit_flag          <= 1'b0;
      safe_monitor_chain_error <= 1'b0;
      spi_error                <= 1'b0;
      alert_packet_out         <= 1'b0;
      rx_clear_out             <= 1'b0;
    end else begin
      if (bal_expire)
        sleep_exit_flag <= 1'b1; // RULE7
      else if (rd_op_alert)
        sleep_exit_flag <= 1'b0;
      if (safe_monitor_mode_in && chain_error_in)
        safe_monitor_chain_error <= 1'b1; // RULE16
      else if (rd_op_status)
        safe_monitor_chain_error <= 1'b0;
      if (cmd_reject)
        spi_error <= 1'b1; // RULE17
      else if (rd_gen)
        spi_error <= 1'b0;
      alert_packet_out <= pkt_enable && tick && (pkt_cnt == pkt_limit - 8'h01) && !sleep_enter; // RULE4 RULE5
      rx_clear_out     <= cmd_ok && (host_in.data == CMD_CLR_RX_BUF);
    end
  end

  // ---------------------------------------------------------------
  // reply byte for reads
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      host_reply_out <= REG_RESET;
    end else if (cmd_ok) begin
      case (host_in.data)
        CMD_RD_RX_STATUS:      host_reply_out <= rx_status_in; // RULE15
        CMD_RD_GEN_STATUS:     host_reply_out <= 8'(spi_error) << SPI_ERR_BIT;
        CMD_RD_OPSTATE_ALERT:  host_reply_out <= 8'(sleep_exit_flag) << SLEEP_EXIT_BIT;
        CMD_RD_OPSTATE_STATUS: host_reply_out <= 8'(safe_monitor_chain_error) << SAFE_CHAIN_ERR_BIT;
        default:               host_reply_out <= REG_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmit buffer and send engine
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (buf_wr)
      tx_buf[wr_ptr] <= host_in.data; // RULE9
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_len   <= 8'h00;
      load_len <= 8'h00;
      wr_ptr   <= '0;
    end else if (byte_in && state == ST_LEN) begin
      load_len <= len_cap;
      tx_len   <= len_cap; // RULE13
      wr_ptr   <= '0;
    end else if (buf_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end else if (cmd_ok && host_in.data == CMD_CLR_TX_BUF) begin
      tx_len <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_busy     <= 1'b0;
      rd_ptr      <= '0;
      uart_tx_out <= '0;
    end else if (tx_start) begin
      tx_busy <= 1'b1; // RULE8 RULE10 RULE14
      rd_ptr  <= '0;
      if (uart_ready_in)
        uart_tx_out.valid <= 1'b0;
    end else if (tx_load) begin
      uart_tx_out.valid <= 1'b1;
      uart_tx_out.data  <= tx_buf[rd_ptr];
      rd_ptr            <= rd_ptr + 1'b1;
      if (tx_last)
        tx_busy <= 1'b0; // RULE8
    end else if (uart_ready_in) begin
      uart_tx_out.valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sleep_active_out = sleep_request_bit;
  assign alert_out = sleep_exit_flag // RULE7
                  || (rx_error_in && alert_enable[RX_ERR_ALERT_EN_BIT]) // RULE11
                  || (rx_overflow_in && alert_enable[RX_OVF_ALERT_EN_BIT]);

endmodule : sleep_and_autoreply_control

// ==== rtl/sleep_autoreply_pkg.sv ====
/*
  Constants, command codes, field layouts and carrier types for the
  sleep and automatic-reply control block.
  Assumes a 100 MHz system clock and a byte-level host serial port in front.
*/
package sleep_autoreply_pkg;

  // ---------------------------------------------------------------
  // host command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RD_RX_STATUS      = 8'h01;
  localparam logic [7:0] CMD_WR_ALERT_EN       = 8'h20;
  localparam logic [7:0] CMD_CLR_TX_BUF        = 8'h40;
  localparam logic [7:0] CMD_CLR_RX_BUF        = 8'h42;
  localparam logic [7:0] CMD_WR_TX_CFG         = 8'h66;
  localparam logic [7:0] CMD_TX_QUEUE          = 8'hB0;
  localparam logic [7:0] CMD_WR_LOAD_Q         = 8'hC0;
  localparam logic [7:0] CMD_RD_OPSTATE_STATUS = 8'h5B;
  localparam logic [7:0] CMD_WR_SLEEP          = 8'h5C;
  localparam logic [7:0] CMD_RD_OPSTATE_ALERT  = 8'h5D;
  localparam logic [7:0] CMD_WR_SLEEP_CFG      = 8'h5E;
  localparam logic [7:0] CMD_RD_GEN_STATUS     = 8'h5F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RX_ERR_ALERT_EN_BIT  = 7;
  localparam int RX_OVF_ALERT_EN_BIT  = 3;
  localparam int TX_AUTO_BIT          = 6;
  localparam int SLEEP_REQ_BIT        = 0;
  localparam int SPI_ERR_BIT          = 6;
  localparam int SAFE_CHAIN_ERR_BIT   = 1;
  localparam int SLEEP_EXIT_BIT       = 3;
  localparam int BAL_TIMEOUT_LSB      = 0;
  localparam int BAL_TIMEOUT_W        = 4;
  localparam int SLP_ALERT_EN_BIT     = 4;
  localparam int SCAN_INTERVAL_LSB    = 5;
  localparam int SCAN_INTERVAL_W      = 3;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         TX_BUF_DEPTH  = 64;
  localparam int         TX_PTR_W      = 6;
  localparam logic [7:0] TX_BUF_MAX    = 8'h40;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       frame;
    logic       valid;
    logic [7:0] data;
  } host_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uart_byte_t;

  typedef enum logic [2:0] {ST_CMD, ST_DATA, ST_LEN, ST_LOAD, ST_SKIP} parse_state_t;

endpackage : sleep_autoreply_pkg

// ==== tb/sleep_autoreply_props.sv ====
/*
  Assertion checker for the sleep and automatic-reply control block.
  Assumes it is bound onto the top module and sees only its ports.
*/
module sleep_autoreply_props
  import sleep_autoreply_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  // watched ports
  input wire host_byte_t host_in,
  input wire logic [7:0] host_reply_out,
  input wire logic       cfg_verify_busy_in,
  input wire logic       cfg_load_busy_in,
  input wire logic       safe_monitor_mode_in,
  input wire logic       commanded_alert_packet_cfg_in,
  input wire logic [7:0] rx_status_in,
  input wire logic       rx_error_in,
  input wire logic       rx_overflow_in,
  input wire logic       uart_ready_in,
  input wire uart_byte_t uart_tx_out,
  input wire logic       rx_clear_out,
  input wire logic       sleep_active_out,
  input wire logic       alert_packet_out,
  input wire logic       alert_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte index in frame and latched command
  logic [1:0] nb;
  logic [7:0] cmd;
  wire logic  take   = host_in.frame && host_in.valid;
  wire logic  busy   = cfg_verify_busy_in || cfg_load_busy_in || safe_monitor_mode_in;
  wire logic  slp_wr = take && nb == 2'h1 && cmd == CMD_WR_SLEEP && host_in.data[SLEEP_REQ_BIT];
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || !host_in.frame) nb <= 2'h0;
    else if (host_in.valid && nb != 2'h3) nb <= nb + 2'h1;
  end
  always_ff @(posedge sys_clk_in) begin
    if (take && nb == 2'h0) cmd <= host_in.data;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_sleep_enter: assert property (slp_wr && !busy |=> sleep_active_out)
    else $error("sleep not entered");
  a_sleep_refused: assert property (slp_wr && busy && !sleep_active_out |=> !sleep_active_out)
    else $error("refused sleep entered");
  a_entry_gate: assert property ($rose(sleep_active_out) |-> !$past(busy))
    else $error("sleep entered while busy");
  a_safe_exit: assert property (safe_monitor_mode_in |=> !sleep_active_out)
    else $error("sleep kept in safe mode");
  a_reply_gate: assert property ($rose(uart_tx_out.valid)
    |-> !$past(sleep_active_out, 2) && !$past(safe_monitor_mode_in, 2))
    else $error("transmit started in sleep or safe mode");
  a_tx_hold: assert property (uart_tx_out.valid && !uart_ready_in
    |=> uart_tx_out.valid && $stable(uart_tx_out.data))
    else $error("tx byte dropped");
  a_rx_status: assert property (take && nb == 2'h0 && host_in.data == CMD_RD_RX_STATUS
    |=> host_reply_out == $past(rx_status_in))
    else $error("rx status reply wrong");
  a_exit_alert: assert property ($rose(alert_out) && !rx_error_in && !rx_overflow_in
    |-> $past(sleep_active_out) && !sleep_active_out)
    else $error("alert without cause");
  a_cmd_packets: assert property (alert_packet_out && !$past(sleep_active_out)
    |-> $past(commanded_alert_packet_cfg_in) && !$past(safe_monitor_mode_in))
    else $error("commanded packet while disabled");
  a_reject_clear: assert property (rx_clear_out
    |-> !$past(sleep_active_out) && !$past(safe_monitor_mode_in))
    else $error("command acted on while rejecting");
  c_timeout_exit: cover property ($fell(sleep_active_out) && alert_out);
  c_tx_start: cover property ($rose(uart_tx_out.valid));
  c_refused: cover property (slp_wr && busy);
endmodule : sleep_autoreply_props

bind sleep_and_autoreply_control sleep_autoreply_props u_props (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .host_in(host_in),
  .host_reply_out(host_reply_out), .cfg_verify_busy_in(cfg_verify_busy_in),
  .cfg_load_busy_in(cfg_load_busy_in), .safe_monitor_mode_in(safe_monitor_mode_in),
  .commanded_alert_packet_cfg_in(commanded_alert_packet_cfg_in), .rx_status_in(rx_status_in),
  .rx_error_in(rx_error_in), .rx_overflow_in(rx_overflow_in), .uart_ready_in(uart_ready_in),
  .uart_tx_out(uart_tx_out), .rx_clear_out(rx_clear_out), .sleep_active_out(sleep_active_out),
  .alert_packet_out(alert_packet_out), .alert_out(alert_out));

// ==== tb/uart_sink_model.sv ====
/*
  Far-side UART transmitter sink: answers with ready, promptly or with stalls.
  Assumes the same clock and reset as the block.
*/
module uart_sink_model (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  // control and handshake
  input  wire logic slow_in,
  output logic      ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lfsr;
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) lfsr <= 5'h1F;
    else lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
  end
  // slow mode stalls on a pseudo-random pattern
  assign ready_out = !slow_in || lfsr[0];
endmodule : uart_sink_model

// ==== tb/sleep_and_autoreply_control_test.sv ====
/*
  Self-checking bench for the sleep and automatic-reply control block.
  Assumes the package, the design, the checker and the uart sink model.
*/
module sleep_and_autoreply_control_test
  import sleep_autoreply_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 8;
  logic       clk, rst_n, vbusy, lbusy, safe, cerr, rxe, rxo, pre, slow, capc;
  logic       rdy, rxclr, slp, pkt, alrt;
  logic [7:0] rxs, reply, b, ival;
  host_byte_t host;
  uart_byte_t tx;
  logic [7:0] exp_q[$];
  logic [7:0] ld[$];
  logic [7:0] q[$];
  int         n_errors, n_checks, cyc, n_pkt, w, n_cpk, n_clr;
  sleep_and_autoreply_control #(.TICK_CYC(TK)) dut_u (
    .sys_clk_in(clk), .reset_n_in(rst_n), .host_in(host), .host_reply_out(reply),
    .cfg_verify_busy_in(vbusy), .cfg_load_busy_in(lbusy), .safe_monitor_mode_in(safe),
    .chain_error_in(cerr), .commanded_alert_packet_cfg_in(capc), .alert_packet_interval_in(ival),
    .preamble_in(pre), .rx_status_in(rxs), .rx_error_in(rxe), .rx_overflow_in(rxo),
    .uart_ready_in(rdy), .uart_tx_out(tx), .rx_clear_out(rxclr), .sleep_active_out(slp),
    .alert_packet_out(pkt), .alert_out(alrt));
  uart_sink_model sink_u (.sys_clk_in(clk), .reset_n_in(rst_n), .slow_in(slow), .ready_out(rdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] d[$]);
    foreach (d[i]) begin
      host <= '{frame: 1'b1, valid: 1'b1, data: d[i]};
      @(posedge clk);
    end
    host <= '0;
    @(posedge clk);
  endtask : xfer
  task automatic pulse;
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic drain;
    repeat (300) begin
      @(posedge clk);
      if (exp_q.size() == 0 && !tx.valid) break;
    end
    chk("tx_left", 8'h00, 8'(exp_q.size()));
  endtask : drain
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // uart monitor and timeout
  // ----------------------------------------
  always @(negedge clk) begin
    if (rst_n && tx.valid && rdy) begin
      if (exp_q.size() == 0) chk("tx_unexpected", 8'h00, {7'h00, tx.valid});
      else chk("tx_byte", exp_q.pop_front(), tx.data);
    end
    if (pkt && slp) n_pkt++;
    if (pkt && !slp) n_cpk++;
    if (rxclr) n_clr++;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {rst_n, vbusy, lbusy, safe, cerr, rxe, rxo, pre, slow} <= '0;
    rxs  <= 8'h00;
    host <= '0;
    capc <= 1'b1;
    void'($urandom(63248));
    ival <= 8'($urandom_range(3));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer('{CMD_WR_ALERT_EN, 8'h88});
    for (int i = 1; i < 5; i++) begin
      {rxo, rxe} <= 2'(i);
      @(posedge clk);
      @(posedge clk);
      chk("alert_out", {7'h00, i < 4}, {7'h00, alrt});
    end
    rxs <= 8'($urandom);
    xfer('{CMD_RD_RX_STATUS});
    chk("rx_status", rxs, reply);
    xfer('{CMD_CLR_RX_BUF, 8'h00});
    xfer('{CMD_CLR_TX_BUF, 8'h00});
    q = '{CMD_WR_LOAD_Q, 8'h06};
    repeat (6) begin
      b = 8'($urandom);
      q.push_back(b);
      ld.push_back(b);
    end
    q.push_back(8'hAA);
    xfer(q);
    xfer('{CMD_WR_TX_CFG, 8'h40});
    slow <= 1'b1;
    exp_q = ld;
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    @(posedge clk);
    pulse();
    drain();
    exp_q = ld;
    slow <= 1'b0;
    xfer('{CMD_TX_QUEUE});
    drain();
    // commanded packets: one every (interval + 1) ticks, none when disabled
    w = (ival + 1) * TK;
    n_cpk = 0;
    repeat (40) @(posedge clk);
    chk("cmd_packets", 8'h01, {7'h00, n_cpk >= 40 / w && n_cpk <= 40 / w + 1});
    capc <= 1'b0;
    @(posedge clk);
    n_cpk = 0;
    repeat (40) @(posedge clk);
    chk("cmd_packets_off", 8'h00, 8'(n_cpk));
    capc <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {safe, lbusy, vbusy} <= 3'(1 << i);
      xfer('{CMD_WR_SLEEP, 8'h01});
      chk("sleep_refused", 8'h00, {7'h00, slp});
    end
    cerr <= 1'b1;
    pulse();
    xfer('{CMD_RD_OPSTATE_STATUS});
    chk("chain_error", 8'h02, reply & 8'h02);
    {safe, cerr} <= 2'b00;
    xfer('{CMD_WR_SLEEP, 8'h01});
    chk("sleep_on", 8'h01, {7'h00, slp});
    n_pkt = 0;
    pulse();
    xfer('{CMD_WR_TX_CFG, 8'h00});
    xfer('{CMD_CLR_RX_BUF, 8'h00});
    xfer('{CMD_RD_GEN_STATUS});
    chk("spi_error", 8'h40, reply & 8'h40);
    chk("rx_clear", 8'h01, 8'(n_clr));
    repeat (40) @(posedge clk);
    chk("sleep_packets", 8'h00, 8'(n_pkt));
    xfer('{CMD_WR_SLEEP, 8'h00});
    chk("sleep_off", 8'h00, {7'h00, slp});
    exp_q = ld;
    pulse();
    drain();
    xfer('{CMD_WR_SLEEP_CFG, 8'h12});
    xfer('{CMD_WR_SLEEP, 8'h01});
    n_pkt = 0;
    for (w = 0; w < 200 && slp === 1'b1; w++) @(posedge clk);
    chk("timeout_len", 8'h01, {7'h00, w >= TK && w <= 3 * TK + 4});
    chk("sleep_exit", 8'h00, {7'h00, slp});
    chk("wake_alert", 8'h01, {7'h00, alrt});
    chk("sleep_packets", 8'h01, {7'h00, n_pkt > 0});
    xfer('{CMD_RD_OPSTATE_ALERT});
    chk("exit_flag", 8'h08, reply & 8'h08);
    final_report();
  end
endmodule : sleep_and_autoreply_control_test
